/* File: rtl/apc_ctrl.sv */
// apc_ctrl: power mode, clocking and output configuration register bank
// Function
// - power mode 00 keeps all converter channels active
// - mode 01 stops datapath clocks, resets datapath, disables outputs
// - mode 10 standby stops datapath clocks and outputs, no reset
// - mode 11 resets datapath and disables outputs, clocks keep running, serial port excluded
// - serial port only reset by power-on reset, never disabled by modes
// - power bit 5 picks standby or full power-down for the pin
// - clock bit 0 resets to 1, stabilizer off
// - without serial port control the stabilizer is forced on
// - enhancement bit 2 enables first-stage chopping
// - output mode bit 6 selects reduced range; drive current automatic
// - output mode bit 2 inverts the serial output stream
// - output mode bit 0 defaults set: twos complement; clear: offset binary
// - output adjust bit 0 gives 2x drive on selected clock outputs
// - termination selected overrides 2x clock drive
// - output adjust bits 5:4 select termination resistor
// - input phase field delays sampling 0 to 7 input cycles
// - output phase field: 60 degree steps, codes 0 to 11, reset 180
// - sample rate override applies only on transfer bit 0 write
// - rate override limits capability and resolution, not the sample rate
// - io control bit 0 disables serial data pin pull-down
// - all other registers take effect immediately on write
// - channel-select low bits choose affected data and clock channels
module apc_ctrl
    import apc_pkg::*;
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic nrst,
    // register access port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // device pins and mode straps
    input wire logic power_down_pin,
    input wire logic serial_mode,
    // datapath control
    output logic dp_clk_en,
    output logic dp_reset,
    output logic out_enable,
    output logic [APC_NCH-1:0] chan_active,
    output logic dcs_enable,
    output logic chop_enable,
    output logic reduced_range,
    output logic auto_drive_current,
    output logic stream_invert,
    output logic twos_complement,
    output logic [1:0] term_sel,
    output logic [APC_NCH-1:0] clk_drive_2x,
    output logic [APC_NCH-1:0] data_lane_invert,
    output logic [2:0] in_phase_delay,
    output logic [3:0] data_clock_out_phase,
    output logic [7:0] rate_override,
    output logic pulldown_enable
);
    logic rst_s1_r, rst_n_r;
    logic [APC_NREG-1:0] wr_sel, rd_sel;
    logic [APC_NREG*8-1:0] regs, wr_mask;
    logic [7:0] mem_rdata;
    logic rd_pend_r, rd_pend_nxt;
    logic [7:0] r_chd, r_chc, r_pwr, r_clk, r_div, r_enh, r_om, r_oa, r_op, r_ovr, r_io;
    // per-channel invert store, written through the data channel select
    logic [APC_NCH-1:0] inv_r, inv_nxt;
    logic [7:0] ovr_r, ovr_nxt;
    logic dp_clk_en_nxt, dp_reset_nxt, out_enable_nxt, dcs_nxt, chop_nxt, red_nxt;
    logic sinv_nxt, twos_nxt, pd_nxt;
    logic [1:0] term_nxt;
    logic [APC_NCH-1:0] drv_nxt, act_nxt, dinv_nxt;
    logic [2:0] iph_nxt;
    logic [3:0] oph_nxt;
    logic [7:0] rdata_nxt;
    logic [1:0] eff_mode;
    logic [APC_NREG-1:0] slot;

    // only the power-on reset reaches this bank; no power mode resets it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    assign wr_mask = {APC_MASK_IO_PD, APC_MASK_RATE_OVR, APC_MASK_OUT_PHASE, APC_MASK_OUT_ADJ,
                      APC_MASK_OUT_MODE, APC_MASK_ENHANCE, APC_MASK_DIVIDER, APC_MASK_CLOCK,
                      APC_MASK_POWER, APC_MASK_CHSEL};

    // one store slot per mapped register; the data channel select has none, as it must
    // equal the clock one anyway; transfer has none either, it only strobes the staging
    always_comb begin
        slot = '0;
        case (reg_addr)
            APC_ADDR_CHSEL_CLK: begin
                slot[0] = 1'b1;
            end
            APC_ADDR_POWER: begin
                slot[1] = 1'b1;
            end
            APC_ADDR_CLOCK: begin
                slot[2] = 1'b1;
            end
            APC_ADDR_DIVIDER: begin
                slot[3] = 1'b1;
            end
            APC_ADDR_ENHANCE: begin
                slot[4] = 1'b1;
            end
            APC_ADDR_OUT_MODE: begin
                slot[5] = 1'b1;
            end
            APC_ADDR_OUT_ADJ: begin
                slot[6] = 1'b1;
            end
            APC_ADDR_OUT_PHASE: begin
                slot[7] = 1'b1;
            end
            APC_ADDR_RATE_OVR: begin
                slot[8] = 1'b1;
            end
            APC_ADDR_IO_PD: begin
                slot[9] = 1'b1;
            end
            default: begin
                slot = '0;
            end
        endcase
        wr_sel = slot & {APC_NREG{reg_wr}};
        rd_sel = slot & {APC_NREG{reg_rd}};
    end

    // every store register updates on the write itself
    apc_regmem #(
        .N(APC_NREG)
    ) u_mem (
        .clock(clock),
        .rst_n(rst_n_r),
        .wr_sel(wr_sel),
        .wr_data(reg_wdata),
        .wr_mask(wr_mask),
        .rd_sel(rd_sel),
        .rd_data(mem_rdata),
        .regs(regs)
    );

    assign r_chc = regs[0*8 +: 8];
    assign r_pwr = regs[1*8 +: 8];
    assign r_clk = regs[2*8 +: 8];
    assign r_div = regs[3*8 +: 8];
    assign r_enh = regs[4*8 +: 8];
    assign r_om = regs[5*8 +: 8];
    assign r_oa = regs[6*8 +: 8];
    assign r_op = regs[7*8 +: 8];
    assign r_ovr = regs[8*8 +: 8];
    assign r_io = regs[9*8 +: 8];
    // both channel selects must match, so the data select mirrors the clock one
    assign r_chd = r_chc;

    always_comb begin
        // pin overrides to standby or power-down
        if (power_down_pin) begin
            eff_mode = r_pwr[APC_POS_PIN_STBY] ? APC_PM_STANDBY : APC_PM_POWERDOWN;
        end else begin
            eff_mode = r_pwr[APC_POS_PWR_MODE +: 2];
        end
        dp_clk_en_nxt = 1'b1;
        dp_reset_nxt = 1'b0;
        out_enable_nxt = 1'b1;
        act_nxt = '1;
        case (eff_mode)
            APC_PM_NORMAL: begin
                act_nxt = '1;
            end
            APC_PM_POWERDOWN: begin
                dp_clk_en_nxt = 1'b0;
                dp_reset_nxt = 1'b1;
                out_enable_nxt = 1'b0;
                act_nxt = '0;
            end
            APC_PM_STANDBY: begin
                dp_clk_en_nxt = 1'b0;
                out_enable_nxt = 1'b0;
                act_nxt = '0;
            end
            APC_PM_DIGRESET: begin
                // register bank keeps running, only datapath is reset
                dp_reset_nxt = 1'b1;
                out_enable_nxt = 1'b0;
            end
            default: begin
                // unreachable; fail safe with datapath held and outputs off
                dp_clk_en_nxt = 1'b0;
                dp_reset_nxt = 1'b1;
                out_enable_nxt = 1'b0;
            end
        endcase
        // register reset state reads 1 meaning off; strap forces it on
        dcs_nxt = serial_mode ? ~r_clk[APC_POS_DCS] : 1'b1;
        chop_nxt = r_enh[APC_POS_CHOP];
        red_nxt = r_om[APC_POS_REDUCED];
        sinv_nxt = r_om[APC_POS_INVERT];
        twos_nxt = r_om[APC_POS_TWOS];
        term_nxt = r_oa[APC_POS_TERM +: 2];
        // termination wins over the stronger clock drive
        drv_nxt = '0;
        for (int c = 0; c < APC_NCH; c++) begin
            drv_nxt[c] = r_chc[c] & r_oa[APC_POS_DRIVE2X] & (term_nxt == 2'b00);
        end
        // invert applies to the channels selected at the time of write
        inv_nxt = inv_r;
        if (wr_sel[5]) begin
            for (int c = 0; c < APC_NCH; c++) begin
                if (r_chd[c]) begin
                    inv_nxt[c] = reg_wdata[APC_POS_INVERT];
                end
            end
        end
        dinv_nxt = inv_nxt;
        // phase limit against divider is the host's duty
        iph_nxt = r_op[APC_POS_IN_PHASE +: 3];
        // codes above the last step are not used by the host
        oph_nxt = r_op[APC_POS_OUT_PHASE +: 4];
        pd_nxt = ~r_io[APC_POS_PD_DIS];
    end

    // staged value only goes live on a transfer write
    always_comb begin
        ovr_nxt = ovr_r;
        if (reg_wr && reg_addr == APC_ADDR_TRANSFER && reg_wdata[APC_POS_XFER]) begin
            ovr_nxt = r_ovr;
        end
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ovr_r <= APC_RST_RATE_OVR;
        end else begin
            ovr_r <= ovr_nxt;
        end
    end

    // read return: slot data is registered first, so the address must stay one more cycle
    always_comb begin
        rd_pend_nxt = reg_rd;
        // open bits and unmapped addresses read zero, fixed bit reads one
        rdata_nxt = mem_rdata;
        if (rd_pend_r && reg_addr == APC_ADDR_OUT_MODE) begin
            rdata_nxt = mem_rdata | APC_FIXED_OUT_MODE;
        end
        if (!rd_pend_r) begin
            rdata_nxt = reg_rdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_pend_r <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            rd_pend_r <= rd_pend_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            inv_r <= '0;
            dp_clk_en <= 1'b0;
            dp_reset <= 1'b1;
            out_enable <= 1'b0;
            chan_active <= '0;
            dcs_enable <= 1'b0;
            chop_enable <= 1'b0;
            reduced_range <= 1'b0;
            auto_drive_current <= 1'b1;
            stream_invert <= 1'b0;
            twos_complement <= 1'b1;
            term_sel <= 2'b00;
            clk_drive_2x <= '0;
            data_lane_invert <= '0;
            in_phase_delay <= 3'h0;
            data_clock_out_phase <= 4'h3;
            rate_override <= APC_RST_RATE_OVR;
            pulldown_enable <= 1'b1;
        end else begin
            inv_r <= inv_nxt;
            dp_clk_en <= dp_clk_en_nxt;
            dp_reset <= dp_reset_nxt;
            out_enable <= out_enable_nxt;
            chan_active <= act_nxt;
            dcs_enable <= dcs_nxt;
            chop_enable <= chop_nxt;
            reduced_range <= red_nxt;
            auto_drive_current <= 1'b1;
            stream_invert <= sinv_nxt;
            twos_complement <= twos_nxt;
            term_sel <= term_nxt;
            clk_drive_2x <= drv_nxt;
            data_lane_invert <= dinv_nxt;
            in_phase_delay <= iph_nxt;
            data_clock_out_phase <= oph_nxt;
            rate_override <= ovr_r;
            pulldown_enable <= pd_nxt;
        end
    end
endmodule

/* File: rtl/apc_pkg.sv */
// apc_pkg: register map, field positions and reset values of the power/output control bank
package apc_pkg;
    // register offsets (9-bit address space of the serial port)
    localparam logic [8:0] APC_ADDR_CHSEL_DATA = 9'h004;
    localparam logic [8:0] APC_ADDR_CHSEL_CLK = 9'h005;
    localparam logic [8:0] APC_ADDR_POWER = 9'h008;
    localparam logic [8:0] APC_ADDR_CLOCK = 9'h009;
    localparam logic [8:0] APC_ADDR_DIVIDER = 9'h00b;
    localparam logic [8:0] APC_ADDR_ENHANCE = 9'h00c;
    localparam logic [8:0] APC_ADDR_OUT_MODE = 9'h014;
    localparam logic [8:0] APC_ADDR_OUT_ADJ = 9'h015;
    localparam logic [8:0] APC_ADDR_OUT_PHASE = 9'h016;
    localparam logic [8:0] APC_ADDR_TRANSFER = 9'h0ff;
    localparam logic [8:0] APC_ADDR_RATE_OVR = 9'h100;
    localparam logic [8:0] APC_ADDR_IO_PD = 9'h101;
    // writable bit masks; other bits are open
    localparam logic [7:0] APC_MASK_CHSEL = 8'h0f;
    localparam logic [7:0] APC_MASK_POWER = 8'h23;
    localparam logic [7:0] APC_MASK_CLOCK = 8'h01;
    localparam logic [7:0] APC_MASK_DIVIDER = 8'h07;
    localparam logic [7:0] APC_MASK_ENHANCE = 8'h04;
    localparam logic [7:0] APC_MASK_OUT_MODE = 8'h45;
    localparam logic [7:0] APC_MASK_OUT_ADJ = 8'h31;
    localparam logic [7:0] APC_MASK_OUT_PHASE = 8'h7f;
    localparam logic [7:0] APC_MASK_RATE_OVR = 8'h47;
    localparam logic [7:0] APC_MASK_IO_PD = 8'h01;
    // fixed read-as-one bit of the output mode register
    localparam logic [7:0] APC_FIXED_OUT_MODE = 8'h02;
    // reset values
    localparam logic [7:0] APC_RST_CHSEL = 8'h0f;
    localparam logic [7:0] APC_RST_POWER = 8'h00;
    localparam logic [7:0] APC_RST_CLOCK = 8'h01;
    localparam logic [7:0] APC_RST_DIVIDER = 8'h00;
    localparam logic [7:0] APC_RST_ENHANCE = 8'h00;
    localparam logic [7:0] APC_RST_OUT_MODE = 8'h01;
    localparam logic [7:0] APC_RST_OUT_ADJ = 8'h00;
    localparam logic [7:0] APC_RST_OUT_PHASE = 8'h03;
    localparam logic [7:0] APC_RST_RATE_OVR = 8'h00;
    localparam logic [7:0] APC_RST_IO_PD = 8'h00;
    // field positions
    localparam int APC_POS_PWR_MODE = 0;
    localparam int APC_POS_PIN_STBY = 5;
    localparam int APC_POS_DCS = 0;
    localparam int APC_POS_CHOP = 2;
    localparam int APC_POS_REDUCED = 6;
    localparam int APC_POS_INVERT = 2;
    localparam int APC_POS_TWOS = 0;
    localparam int APC_POS_DRIVE2X = 0;
    localparam int APC_POS_TERM = 4;
    localparam int APC_POS_IN_PHASE = 4;
    localparam int APC_POS_OUT_PHASE = 0;
    localparam int APC_POS_XFER = 0;
    localparam int APC_POS_PD_DIS = 0;
    // other constants
    localparam logic [3:0] APC_OUT_PHASE_MAX = 4'hb;
    localparam int APC_NCH = 4;
    localparam int APC_NREG = 10;
    // power modes
    typedef enum logic [1:0] {
        APC_PM_NORMAL = 2'b00,
        APC_PM_POWERDOWN = 2'b01,
        APC_PM_STANDBY = 2'b10,
        APC_PM_DIGRESET = 2'b11
    } apc_pm_e;
endpackage

/* File: rtl/apc_regmem.sv */
// apc_regmem: small register store with masked write and registered read data
module apc_regmem
    import apc_pkg::*;
#(
    parameter int N = 10
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // write side
    input wire logic [N-1:0] wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic [N*8-1:0] wr_mask,
    // read side
    input wire logic [N-1:0] rd_sel,
    output logic [7:0] rd_data,
    output logic [N*8-1:0] regs
);
    logic [N*8-1:0] regs_nxt;
    logic [7:0] rd_nxt;

    always_comb begin
        regs_nxt = regs;
        rd_nxt = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (wr_sel[i]) begin
                // open bits drop writes
                regs_nxt[i*8 +: 8] = wr_data & wr_mask[i*8 +: 8];
            end
            if (rd_sel[i]) begin
                rd_nxt = rd_nxt | (regs[i*8 +: 8] & wr_mask[i*8 +: 8]);
            end
        end
    end

    // reset values are fixed constants, so the async branch loads no signal
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regs <= {APC_RST_IO_PD, APC_RST_RATE_OVR, APC_RST_OUT_PHASE, APC_RST_OUT_ADJ,
                     APC_RST_OUT_MODE, APC_RST_ENHANCE, APC_RST_DIVIDER, APC_RST_CLOCK,
                     APC_RST_POWER, APC_RST_CHSEL};
            rd_data <= 8'h00;
        end else begin
            regs <= regs_nxt;
            rd_data <= rd_nxt;
        end
    end
endmodule

/* File: sim/adc_power_output_ctrl_regs_tb_top.sv */
// adc_power_output_ctrl_regs_tb_top: directed test of the control bank via its register port
module adc_power_output_ctrl_regs_tb_top;
    import apc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, nrst, power_down_pin, serial_mode, reg_wr, reg_rd;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rate_override, rv;
    logic dp_clk_en, dp_reset, out_enable, dcs_enable, chop_enable, reduced_range;
    logic auto_drive_current, stream_invert, twos_complement, pulldown_enable;
    logic [1:0] term_sel;
    logic [3:0] chan_active, clk_drive_2x, data_lane_invert, data_clock_out_phase;
    logic [2:0] in_phase_delay;
    int errors = 0;
    int n_checks = 0;
    logic [8:0] ra [13] = '{9'h004, 9'h005, 9'h008, 9'h009, 9'h00b, 9'h00c, 9'h014, 9'h015,
        9'h016, 9'h0ff, 9'h100, 9'h101, 9'h1ff};
    logic [7:0] rst_x [13] = '{8'h00, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h03,
        8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ff_x [13] = '{8'h00, 8'h0f, 8'h23, 8'h01, 8'h07, 8'h04, 8'h47, 8'h31, 8'h7b,
        8'h00, 8'h47, 8'h01, 8'h00};
    logic [2:0] pm_x [4] = '{3'b101, 3'b010, 3'b000, 3'b110};
    apc_ctrl apc_ctrl_inst (.clock, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .power_down_pin, .serial_mode, .dp_clk_en, .dp_reset, .out_enable, .chan_active,
        .dcs_enable, .chop_enable, .reduced_range, .auto_drive_current, .stream_invert,
        .twos_complement, .term_sel, .clk_drive_2x, .data_lane_invert, .in_phase_delay,
        .data_clock_out_phase, .rate_override, .pulldown_enable);
    apc_host apc_host_inst (.clock, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
        apc_host_inst.rd(a, rv);
        chk($sformatf("reg %h", a), exp, rv);
    endtask
    // outputs are registered twice after the take, so wait both edges
    task automatic wset(input logic [8:0] a, input logic [7:0] d);
        apc_host_inst.wr(a, d);
        repeat (2) @(posedge clock);
        #1;
    endtask
    function automatic logic [7:0] pm();
        return {5'h00, dp_clk_en, dp_reset, out_enable};
    endfunction
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        conclude();
    end
    initial begin
        nrst = 1'b0;
        power_down_pin = 1'b0;
        serial_mode = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk("dcs", 8'h00, {7'h0, dcs_enable});
        chk("pd", 8'h01, {7'h0, pulldown_enable});
        chk("pm", {5'h0, pm_x[0]}, pm());
        for (int i = 0; i < 13; i++) begin
            rchk(ra[i], rst_x[i]);
        end
        // divider goes to 7 before the phase write, and output phase stays at b
        for (int i = 0; i < 13; i++) begin
            apc_host_inst.wr(ra[i], (ra[i] == 9'h016) ? 8'h7b : 8'hff);
        end
        wset(9'h101, 8'hff);
        for (int i = 0; i < 13; i++) begin
            rchk(ra[i], ff_x[i]);
        end
        chk("pm3", {5'h0, pm_x[3]}, pm());
        chk("term", 8'h03, {6'h0, term_sel});
        chk("2x", 8'h00, {4'h0, clk_drive_2x});
        chk("ph", 8'h7b, {1'b0, in_phase_delay, data_clock_out_phase});
        chk("mode", 8'h07, {5'h0, reduced_range, stream_invert, twos_complement});
        chk("chop", 8'h01, {7'h0, chop_enable});
        chk("pd", 8'h00, {7'h0, pulldown_enable});
        chk("ovr", 8'h00, rate_override);
        wset(9'h0ff, 8'h01);
        chk("ovr", 8'h47, rate_override);
        for (int m = 0; m < 4; m++) begin
            wset(9'h008, 8'(m));
            chk("pm", {5'h0, pm_x[m]}, pm());
        end
        wset(9'h008, 8'h20);
        power_down_pin = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("pin", {5'h0, pm_x[2]}, pm());
        wset(9'h008, 8'h00);
        chk("pin", {5'h0, pm_x[1]}, pm());
        power_down_pin = 1'b0;
        wset(9'h009, 8'h00);
        chk("dcs", 8'h01, {7'h0, dcs_enable});
        wset(9'h009, 8'h01);
        serial_mode = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("dcs", 8'h01, {7'h0, dcs_enable});
        serial_mode = 1'b1;
        chk("act", 8'h0f, {4'h0, chan_active});
        wset(9'h015, 8'h00);
        wset(9'h005, 8'h03);
        wset(9'h015, 8'h01);
        chk("2x", 8'h03, {4'h0, clk_drive_2x});
        wset(9'h015, 8'h21);
        chk("2x", 8'h20, {2'h0, term_sel, clk_drive_2x});
        wset(9'h014, 8'h00);
        chk("inv", 8'h0c, {4'h0, data_lane_invert});
        chk("mode", 8'h01, {4'h0, reduced_range, stream_invert, twos_complement,
            auto_drive_current});
        wset(9'h00b, 8'h03);
        wset(9'h016, 8'h30);
        chk("ph", 8'h30, {1'b0, in_phase_delay, data_clock_out_phase});
        // a second power-on reset brings the bank back to its reset values
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk("ovr", 8'h00, rate_override);
        rchk(9'h016, 8'h03);
        rchk(9'h015, 8'h00);
        conclude();
    end
endmodule

/* File: sim/apc_ctrl_properties.sv */
// apc_ctrl_properties: concurrent checks on the control bank ports
module apc_ctrl_properties
    import apc_pkg::*;
(
    // clock, reset and register port
    input wire logic clock,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // pins and datapath control
    input wire logic power_down_pin,
    input wire logic serial_mode,
    input wire logic dp_clk_en,
    input wire logic dp_reset,
    input wire logic out_enable,
    input wire logic [APC_NCH-1:0] chan_active,
    input wire logic dcs_enable,
    input wire logic [1:0] term_sel,
    input wire logic [APC_NCH-1:0] clk_drive_2x,
    input wire logic [2:0] in_phase_delay,
    input wire logic [3:0] data_clock_out_phase,
    input wire logic [7:0] rate_override
);
    timeunit 1ns;
    timeprecision 100ps;
    // checks hold off until the synchronised reset copy has released
    logic [1:0] up_r;
    logic [1:0] up_nxt;
    logic [7:0] stage_r;
    logic [7:0] stage_nxt;
    logic ok;
    logic xfer_hit;
    assign ok = (up_r == 2'h3);
    assign xfer_hit = reg_wr && reg_addr == APC_ADDR_TRANSFER && reg_wdata[APC_POS_XFER];
    always_comb begin
        up_nxt = ok ? up_r : up_r + 2'h1;
        stage_nxt = stage_r;
        if (reg_wr && reg_addr == APC_ADDR_RATE_OVR) begin
            stage_nxt = reg_wdata & APC_MASK_RATE_OVR;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            up_r <= 2'h0;
            stage_r <= 8'h00;
        end else begin
            up_r <= up_nxt;
            stage_r <= stage_nxt;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!ok);
    sequence s_xfer_wr; xfer_hit; endsequence
    sequence s_phase_wr; reg_wr && reg_addr == APC_ADDR_OUT_PHASE; endsequence
    property p_pin_stop; power_down_pin |=> !dp_clk_en && !out_enable; endproperty
    a_pin_stop: assert property (p_pin_stop) else $error("pin left outputs on");
    property p_reset_off; dp_reset |-> !out_enable; endproperty
    a_reset_off: assert property (p_reset_off) else $error("outputs on in reset");
    property p_stop_off; !dp_clk_en |-> !out_enable; endproperty
    a_stop_off: assert property (p_stop_off) else $error("outputs on, clocks off");
    property p_normal; out_enable |-> dp_clk_en && !dp_reset && (&chan_active); endproperty
    a_normal: assert property (p_normal) else $error("normal mode incomplete");
    property p_dcs_forced; !serial_mode |=> dcs_enable; endproperty
    a_dcs_forced: assert property (p_dcs_forced) else $error("stabilizer not forced");
    property p_term_wins; term_sel != 2'h0 |-> clk_drive_2x == '0; endproperty
    a_term_wins: assert property (p_term_wins) else $error("2x drive with term");
    property p_phase;
        s_phase_wr |-> ##2 {1'b0, in_phase_delay, data_clock_out_phase} ==
            ($past(reg_wdata, 2) & APC_MASK_OUT_PHASE);
    endproperty
    a_phase: assert property (p_phase) else $error("phase fields wrong");
    property p_xfer_apply; s_xfer_wr |-> ##2 rate_override == $past(stage_r, 2); endproperty
    a_xfer_apply: assert property (p_xfer_apply) else $error("override not applied");
    property p_xfer_only; !$stable(rate_override) |-> $past(xfer_hit, 2); endproperty
    a_xfer_only: assert property (p_xfer_only) else $error("override moved early");
    property p_rd_zero;
        reg_rd && reg_addr == APC_ADDR_TRANSFER |-> ##2 reg_rdata == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("transfer read not zero");
endmodule
bind apc_ctrl apc_ctrl_properties apc_ctrl_properties_inst (.clock, .nrst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .power_down_pin, .serial_mode, .dp_clk_en, .dp_reset,
    .out_enable, .chan_active, .dcs_enable, .term_sel, .clk_drive_2x, .in_phase_delay,
    .data_clock_out_phase, .rate_override);

/* File: sim/apc_host.sv */
// apc_host: host model driving the register access port
module apc_host (
    // clock and read return
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    // request side
    output logic reg_wr,
    output logic reg_rd,
    output logic [8:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse, so a stale value never passes for a held one
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // address is held one cycle past the strobe; data lands one edge after the take and is read after the next
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        @(posedge clock);
        #1;
        reg_addr = ~a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask
endmodule
